// >>> hdl/uart_psave_pkg.sv
// ============================================================
// Power-saving control constants
package uart_psave_pkg;

  // Power-saving setting codes
  localparam logic [1:0] PSV_OFF    = 2'h0;
  localparam logic [1:0] PSV_CYCLIC = 2'h1;
  localparam logic [1:0] PSV_RTS    = 2'h2;
  localparam logic [1:0] PSV_DTR    = 2'h3;

  // Values after reset
  localparam logic [1:0]  MODE_RESET      = PSV_OFF;
  localparam logic [15:0] TIMEOUT_RESET   = 16'h07d0;  // 2000 frames
  localparam logic [15:0] TIMEOUT_MIN     = 16'h0028;  // 40 frames
  localparam logic [15:0] TIMEOUT_MAX     = 16'hfde8;  // 65000 frames

  // First-variant version from which CTS follows its level setting
  localparam logic [7:0]  CTS_LEVEL_VERSION = 8'h02;

  // Timing: clock period, wake-up time, 2G frame time
  localparam int CLK_PERIOD_NS = 20;
  localparam int WAKE_TIME_US  = 20000;
  localparam int FRAME_TIME_NS = 4615000;
  localparam int WAKE_CYCLES   = WAKE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int FRAME_CYCLES  = FRAME_TIME_NS / CLK_PERIOD_NS;

  // Active/idle states
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_IDLE,
    ST_WAKE
  } power_state_t;

endpackage : uart_psave_pkg

// >>> hdl/uart_psave_wake.sv
// Contract
// - Setting 2 accepted only with flow control off
// - Setting 2: port off when RTS drops
// - RTS off keeps port off except exceptions
// - RTS rising re-enables; idle wakes after 20ms
// - RTS on: no idle, port enabled
// - Setting 2 CTS by version policy
// - Setting 3 only on second variant
// - Setting 3: port off while DTR off
// - DTR rising re-enables; idle wakes after 20ms
// - DTR on: no idle, port enabled
// - DTR action behaviour still applied
// - Setting 3 with flow control: CTS shows port
// - Armed TXD rising edge wakes the device
// - First character while disabled is discarded
// - Arming conditions differ per variant
// - Second variant never arms on RTS/DTR off
// - Data wake ends after no-data timeout
// - Data wake cannot be switched off
// - Host sends dummy attention command first
// - Calls keep port enabled
// - Live USB keeps second variant active
// - Timeout in frames, 40 to 65000, default 2000
// - Each received character restarts the timer
// - CTS low when enabled, high when disabled; code: low in setting 0, level setting in 1/3 without flow and in 2 by version
`timescale 1ns/1ps

module uart_psave_wake
  import uart_psave_pkg::*;
#(
  parameter int WAKE_COUNT  = WAKE_CYCLES,
  parameter int FRAME_COUNT = FRAME_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Static product selection
  input  wire logic        second_variant,
  input  wire logic [7:0]  product_version,
  // Setting request from the command layer
  input  wire logic        setting_req,
  input  wire logic [1:0]  power_saving_setting,
  input  wire logic [15:0] timeout_frames,
  input  wire logic        hw_flow_control_on,
  input  wire logic        cts_level_setting,
  output logic             setting_ack,
  output logic             setting_nak,
  // Host lines, high means ON / high level
  input  wire logic        rts_on,
  input  wire logic        dtr_on,
  input  wire logic        txd_level,
  // Activity sources
  input  wire logic        rx_char,
  input  wire logic        unsolicited_result_message,
  input  wire logic        call_active,
  input  wire logic        network_busy,
  input  wire logic        usb_live,
  // Status and pins
  output logic             port_enable,
  output logic             module_active,
  output logic             cts_n,
  output logic             char_discard,
  output logic             dtr_action_event
);

  // ==========================================================
  // Elaboration checks
  localparam int WW = $clog2(WAKE_COUNT + 1);
  localparam int FW = $clog2(FRAME_COUNT + 1);

  if (WAKE_COUNT < 1 || FRAME_COUNT < 1) begin : g_bad_count
    $error("wake and frame counts must be at least one");
  end

  // ==========================================================
  // State
  logic [1:0]   mode;
  logic         flow_on;
  logic [15:0]  timeout;
  power_state_t st;
  logic [WW-1:0] wake_cnt;
  logic [FW-1:0] frame_div;
  logic [15:0]  frame_cnt;
  logic         data_awake;
  logic         dtr_q;
  logic         txd_q;

  logic [1:0]   next_mode;
  logic         next_flow_on;
  logic [15:0]  next_timeout;
  power_state_t next_st;
  logic [WW-1:0] next_wake_cnt;
  logic [FW-1:0] next_frame_div;
  logic [15:0]  next_frame_cnt;
  logic         next_data_awake;
  logic         next_port_enable;
  logic         next_cts_n;
  logic         next_setting_ack;
  logic         next_setting_nak;
  logic         next_char_discard;
  logic         next_dtr_action_event;

  logic         want;
  logic         armed;
  logic         frame_tick;
  logic         legal;

  // Clamp a requested timeout into its legal frame range
  function automatic logic [15:0] clamp_timeout(input logic [15:0] v);
    if (v < TIMEOUT_MIN) begin
      return TIMEOUT_MIN;
    end
    if (v > TIMEOUT_MAX) begin
      return TIMEOUT_MAX;
    end
    return v;
  endfunction : clamp_timeout

  // ==========================================================
  // Next-state computation
  always_comb begin
    next_mode             = mode;
    next_flow_on          = flow_on;
    next_timeout          = timeout;
    next_st               = st;
    next_wake_cnt         = wake_cnt;
    next_frame_div        = frame_div;
    next_frame_cnt        = frame_cnt;
    next_data_awake       = data_awake;
    next_setting_ack      = 1'b0;
    next_setting_nak      = 1'b0;
    next_char_discard     = 1'b0;
    next_dtr_action_event = 1'b0;

    // Setting legality per variant and flow control
    // setting legality
    legal = 1'b1;
    if (power_saving_setting == PSV_RTS && hw_flow_control_on) begin
      legal = 1'b0;
    end
    if (power_saving_setting == PSV_DTR && !second_variant) begin
      legal = 1'b0;
    end
    if (setting_req) begin
      next_flow_on = hw_flow_control_on;
      if (legal) begin
        next_mode        = power_saving_setting;
        next_timeout     = clamp_timeout(timeout_frames);
        next_setting_ack = 1'b1;
      end else begin
        next_setting_nak = 1'b1;
      end
    end

    // Arming needs flow control off; RTS off arms setting 2 on the first variant only
    // arming
    armed = !flow_on && (mode == PSV_CYCLIC ||
            (!second_variant && mode == PSV_RTS && !rts_on));

    // Frame divider runs only while a data wake is held
    frame_tick = data_awake && (frame_div == FW'(FRAME_COUNT - 1));
    if (data_awake) begin
      next_frame_div = frame_tick ? '0 : frame_div + 1'b1;
      if (frame_tick) begin
        next_frame_cnt = frame_cnt + 16'h0001;
      end
      if (rx_char && port_enable) begin
        next_frame_cnt = 16'h0000;
        next_frame_div = '0;
      end else if (frame_cnt >= timeout) begin
        next_data_awake = 1'b0;
      end
    end

    // After the timeout, so a fresh edge beats the clear
    // armed edge wakes
    if (armed && txd_level && !txd_q && !port_enable) begin
      next_data_awake = 1'b1;
      next_frame_cnt  = 16'h0000;
      next_frame_div  = '0;
    end

    // Port wanted by the current setting and pending work
    // port gating
    unique case (mode)
      PSV_OFF:    want = 1'b1;
      PSV_CYCLIC: want = 1'b0;
      PSV_RTS:    want = rts_on;
      PSV_DTR:    want = dtr_on;
    endcase
    want = want || unsolicited_result_message || call_active ||
           data_awake;

    if (rx_char && !port_enable) begin
      next_char_discard = 1'b1;
    end

    if (dtr_q && !dtr_on) begin
      next_dtr_action_event = 1'b1;
    end

    // Active/idle sequencing
    unique case (st)
      ST_ACTIVE: begin
        if (!want && !network_busy && !(second_variant && usb_live)) begin
          next_st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (want || network_busy || (second_variant && usb_live)) begin
          next_st       = ST_WAKE;
          next_wake_cnt = '0;
        end
      end
      ST_WAKE: begin
        if (wake_cnt == WW'(WAKE_COUNT - 1)) begin
          next_st = ST_ACTIVE;
        end else begin
          next_wake_cnt = wake_cnt + 1'b1;
        end
      end
    endcase

    // Port only opens once the module is fully active
    next_port_enable = want && (st == ST_ACTIVE) && (next_st == ST_ACTIVE);

    // CTS policy: ON is low
    // CTS policy
    next_cts_n = !next_port_enable;
    if (mode == PSV_OFF) begin
      next_cts_n = 1'b0;
    end else if (mode == PSV_RTS && !second_variant &&
                 product_version >= CTS_LEVEL_VERSION) begin
      next_cts_n = !cts_level_setting;
    end else if (!flow_on && mode != PSV_RTS) begin
      next_cts_n = !cts_level_setting;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode             <= MODE_RESET;
      flow_on          <= 1'b0;
      timeout          <= TIMEOUT_RESET;
      st               <= ST_ACTIVE;
      wake_cnt         <= '0;
      frame_div        <= '0;
      frame_cnt        <= 16'h0000;
      data_awake       <= 1'b0;
      dtr_q            <= 1'b0;
      txd_q            <= 1'b1;
      port_enable      <= 1'b0;
      module_active    <= 1'b1;
      cts_n            <= 1'b1;
      setting_ack      <= 1'b0;
      setting_nak      <= 1'b0;
      char_discard     <= 1'b0;
      dtr_action_event <= 1'b0;
    end else begin
      mode             <= next_mode;
      flow_on          <= next_flow_on;
      timeout          <= next_timeout;
      st               <= next_st;
      wake_cnt         <= next_wake_cnt;
      frame_div        <= next_frame_div;
      frame_cnt        <= next_frame_cnt;
      data_awake       <= next_data_awake;
      dtr_q            <= dtr_on;
      txd_q            <= txd_level;
      port_enable      <= next_port_enable;
      module_active    <= (next_st == ST_ACTIVE);
      cts_n            <= next_cts_n;
      setting_ack      <= next_setting_ack;
      setting_nak      <= next_setting_nak;
      char_discard     <= next_char_discard;
      dtr_action_event <= next_dtr_action_event;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_set2_flow;
    setting_req && power_saving_setting == PSV_RTS && hw_flow_control_on
      |=> setting_nak && !setting_ack;
  endproperty
  a_set2_flow: assert property (p_set2_flow)
    else $error("setting 2 accepted with flow control on");

  property p_set3_first;
    setting_req && power_saving_setting == PSV_DTR && !second_variant
      |=> setting_nak ##1 (mode != PSV_DTR || $past(mode) == PSV_DTR);
  endproperty
  a_set3_first: assert property (p_set3_first)
    else $error("setting 3 taken on first variant");

  property p_rts_off;
    mode == PSV_RTS && !rts_on && !unsolicited_result_message &&
      !call_active && !data_awake && !setting_req |=> !port_enable;
  endproperty
  a_rts_off: assert property (p_rts_off)
    else $error("port open while RTS off");

  property p_dtr_off;
    mode == PSV_DTR && !dtr_on && !unsolicited_result_message &&
      !call_active && !data_awake && !setting_req |=> !port_enable;
  endproperty
  a_dtr_off: assert property (p_dtr_off)
    else $error("port open while DTR off");

  property p_rts_hold;
    mode == PSV_RTS && rts_on && st == ST_ACTIVE && !setting_req
      |=> port_enable && module_active;
  endproperty
  a_rts_hold: assert property (p_rts_hold)
    else $error("RTS on but port closed");

  property p_wake_time;
    $rose(st == ST_WAKE) |-> (st == ST_WAKE)[*2] or
      (st == ST_WAKE ##1 st == ST_ACTIVE && WAKE_COUNT == 1);
  endproperty
  a_wake_time: assert property (p_wake_time)
    else $error("wake delay cut short");

  property p_discard;
    rx_char && !port_enable |=> char_discard;
  endproperty
  a_discard: assert property (p_discard)
    else $error("character while disabled not discarded");

  property p_cts_flow3;
    mode == PSV_DTR && flow_on |-> ##1 (cts_n == !port_enable);
  endproperty
  a_cts_flow3: assert property (p_cts_flow3)
    else $error("CTS does not mirror port state");

  property p_no_arm_second;
    second_variant && mode == PSV_RTS && !rts_on && !data_awake &&
      !setting_req |=> !data_awake;
  endproperty
  a_no_arm_second: assert property (p_no_arm_second)
    else $error("second variant armed data wake");

  property p_usb_active;
    second_variant && usb_live && st == ST_ACTIVE |=> module_active;
  endproperty
  a_usb_active: assert property (p_usb_active)
    else $error("idle entered with live USB");

  c_data_wake: cover property ($rose(data_awake) ##[1:8] st == ST_WAKE);
  c_rts_wake: cover property (st == ST_IDLE ##1 st == ST_WAKE && rts_on);
  c_idle: cover property (st == ST_ACTIVE ##1 st == ST_IDLE);
  c_timeout: cover property ($fell(data_awake));

endmodule : uart_psave_wake

// >>> sim/host_dte_model.sv
`timescale 1ns/1ps
// ============================================================
// Host terminal model: request lines and transmit-data line
module host_dte_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Commands from the bench
  input  wire logic rts_req,
  input  wire logic dtr_req,
  input  wire logic send_req,
  // Host lines towards the device
  output logic      rts_on,
  output logic      dtr_on,
  output logic      txd_level
);
  logic [2:0] bit_cnt;

  // Request lines follow the bench commands
  assign rts_on = rts_req;
  assign dtr_on = dtr_req;

  // wake character
  // Start bit low a few cycles, then back to idle high, which gives
  // the low-to-high edge; valid text is left until after wake-up
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt <= 3'h0;
    end else if (send_req) begin
      bit_cnt <= 3'h4;
    end else if (bit_cnt != 3'h0) begin
      bit_cnt <= bit_cnt - 3'h1;
    end
  end
  assign txd_level = (bit_cnt == 3'h0);  // Idle line rests high
endmodule : host_dte_model

// >>> sim/test_uart_psave_wake.sv
`timescale 1ns/1ps
// ============================================================
// Bench for the power-saving wake control
module test_uart_psave_wake;
  import uart_psave_pkg::*;
  localparam int WAKE = 8;  // Short wake delay keeps the run brief
  logic        clk_sys, sys_rst, second_variant, setting_req;
  logic        hw_flow_control_on, cts_level_setting, rts_req, dtr_req;
  logic        send_req, rx_char, urm, call_active, network_busy, usb_live;
  logic [7:0]  product_version;
  logic [1:0]  mode;
  logic [15:0] timeout_frames;
  logic        setting_ack, setting_nak, rts_on, dtr_on, txd_level;
  logic        port_enable, module_active, cts_n, char_discard, dtr_ev;
  int          fail_count, checks, n;

  uart_psave_wake #(.WAKE_COUNT(WAKE), .FRAME_COUNT(4)) DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .second_variant(second_variant), .product_version(product_version),
    .setting_req(setting_req), .power_saving_setting(mode),
    .timeout_frames(timeout_frames),
    .hw_flow_control_on(hw_flow_control_on),
    .cts_level_setting(cts_level_setting),
    .setting_ack(setting_ack), .setting_nak(setting_nak),
    .rts_on(rts_on), .dtr_on(dtr_on), .txd_level(txd_level),
    .rx_char(rx_char), .unsolicited_result_message(urm),
    .call_active(call_active), .network_busy(network_busy),
    .usb_live(usb_live), .port_enable(port_enable),
    .module_active(module_active), .cts_n(cts_n),
    .char_discard(char_discard), .dtr_action_event(dtr_ev));

  host_dte_model host (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .rts_req(rts_req),
    .dtr_req(dtr_req), .send_req(send_req), .rts_on(rts_on),
    .dtr_on(dtr_on), .txd_level(txd_level));

  // Clock, 20 ns period
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Closing report, also reached when a wait runs out
  task print_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task check(input string name, input logic [15:0] exp, got);
    checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
      fail_count++;
    end
  endtask : check

  // Inputs change 1 ns after the edge, away from sampling
  task step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step

  // Bounded wait: 0 port, 1 active, 2 DTR event, 3 discard
  task wait_sig(input int which, input logic exp, input int maxc,
                output int cnt);
    logic v;
    cnt = 0;
    v = ~exp;
    while (v !== exp && cnt <= maxc) begin
      step(1);
      cnt++;
      case (which)
        0: v = port_enable;
        1: v = module_active;
        2: v = dtr_ev;
        default: v = char_discard;
      endcase
    end
    checks++;
    if (v !== exp) begin
      $display("wrong value wait %0d expected %0h seen %0h", which, exp, v);
      fail_count++;
      print_verdict();
    end
  endtask : wait_sig

  // One setting request; the answer stands only in the next cycle
  task set_mode(input logic [1:0] m, input logic flow, input logic ok);
    mode = m;
    hw_flow_control_on = flow;
    setting_req = 1'b1;
    step(1);
    setting_req = 1'b0;
    check("setting_ack", ok, setting_ack);
    check("setting_nak", !ok, setting_nak);
    step(1);
  endtask : set_mode

  initial begin
    {setting_req, hw_flow_control_on, second_variant, send_req} = 4'h0;
    {rx_char, urm, call_active, network_busy, usb_live} = 5'h00;
    {cts_level_setting, rts_req, dtr_req, sys_rst} = 4'hf;
    mode = 2'h0;
    timeout_frames = 16'h0000;  // Clamped to the 40-frame minimum
    product_version = 8'h02;
    fail_count = 0;
    checks = 0;
    repeat (6) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    step(2);
    check("port_enable", 1, port_enable);
    check("cts_n", 0, cts_n);
    $display("test reset done");
    set_mode(2'h2, 1'b1, 1'b0);
    set_mode(2'h3, 1'b0, 1'b0);
    set_mode(2'h2, 1'b0, 1'b1);
    step(20);
    check("port_enable", 1, port_enable);
    check("module_active", 1, module_active);
    check("cts_n", 0, cts_n);
    rts_req = 1'b0;
    wait_sig(0, 1'b0, 2, n);
    rx_char = 1'b1;
    wait_sig(3, 1'b1, 2, n);
    rx_char = 1'b0;
    wait_sig(1, 1'b0, 10, n);
    check("cts_n", 0, cts_n);
    product_version = 8'h01;
    step(2);
    check("cts_n", 1, cts_n);
    product_version = 8'h02;
    urm = 1'b1;
    wait_sig(0, 1'b1, WAKE + 6, n);
    urm = 1'b0;
    wait_sig(0, 1'b0, 3, n);
    wait_sig(1, 1'b0, 10, n);
    rts_req = 1'b1;
    wait_sig(0, 1'b1, WAKE + 6, n);
    check("wake delay", 1, n >= WAKE);
    rts_req = 1'b0;
    wait_sig(1, 1'b0, 10, n);
    send_req = 1'b1;
    step(1);
    send_req = 1'b0;
    wait_sig(0, 1'b1, WAKE + 12, n);
    wait_sig(0, 1'b0, 200, n);
    rts_req = 1'b1;
    wait_sig(0, 1'b1, WAKE + 6, n);
    $display("test request-to-send gating done");
    set_mode(2'h1, 1'b0, 1'b1);
    wait_sig(0, 1'b0, 3, n);
    wait_sig(1, 1'b0, 10, n);
    send_req = 1'b1;
    step(1);
    send_req = 1'b0;
    wait_sig(0, 1'b1, WAKE + 12, n);
    step(100);
    rx_char = 1'b1;
    step(1);
    rx_char = 1'b0;
    wait_sig(0, 1'b0, 200, n);
    check("idle timeout", 1, n >= 150);
    $display("test data wake done");
    second_variant = 1'b1;
    set_mode(2'h3, 1'b1, 1'b1);
    wait_sig(0, 1'b1, WAKE + 6, n);
    check("cts_n", 0, cts_n);
    dtr_req = 1'b0;
    wait_sig(2, 1'b1, 3, n);
    step(2);
    check("port_enable", 0, port_enable);
    check("cts_n", 1, cts_n);
    send_req = 1'b1;
    step(1);
    send_req = 1'b0;
    step(30);
    check("port_enable", 0, port_enable);
    dtr_req = 1'b1;
    wait_sig(0, 1'b1, WAKE + 6, n);
    $display("test terminal-ready gating done");
    set_mode(2'h2, 1'b0, 1'b1);
    usb_live = 1'b1;
    rts_req = 1'b0;
    wait_sig(0, 1'b0, 3, n);
    step(10);
    check("module_active", 1, module_active);
    usb_live = 1'b0;
    wait_sig(1, 1'b0, 10, n);
    send_req = 1'b1;
    step(1);
    send_req = 1'b0;
    step(30);
    check("port_enable", 0, port_enable);
    $display("test second variant request-to-send done");
    print_verdict();
  end
endmodule : test_uart_psave_wake
